// *** hdl/dtc_defines.vh ***
// register offsets, field positions, reset values and timing counts of the dual timer
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH
`define DTC_ADDR_RUN_CTRL   8'h88
`define DTC_ADDR_MODE_SEL   8'h89
`define DTC_ADDR_CNT0_LOW   8'h8a
`define DTC_ADDR_CNT1_LOW   8'h8b
`define DTC_ADDR_CNT0_HIGH  8'h8c
`define DTC_ADDR_CNT1_HIGH  8'h8d
`define DTC_ADDR_CLK_CTRL   8'h8e
`define DTC_ADDR_AUX_CTRL   8'h90
`define DTC_ADDR_IRQ_STAT   8'h91
`define DTC_ADDR_IRQ_MASK   8'h92
`define DTC_ADDR_ISR_ACK    8'h93
`define DTC_RESET_BYTE      8'h00
`define DTC_MODE_CT0        2
`define DTC_MODE_GATE0      3
`define DTC_MODE_CT1        6
`define DTC_MODE_GATE1      7
`define DTC_RUN0            4
`define DTC_FLAG0           5
`define DTC_RUN1            6
`define DTC_FLAG1           7
`define DTC_CLK_MODE0       3
`define DTC_CLK_MODE1       4
`define DTC_AUX_TOG0        0
`define DTC_AUX_TOG1        1
`define DTC_AUX_LXT0        2
`define DTC_AUX_LXT1        3
`define DTC_PRESCALE        4'd12
`define DTC_PRESCALE_LAST   4'd11
`define DTC_MODE_13BIT      2'b00
`define DTC_MODE_16BIT      2'b01
`define DTC_MODE_RELOAD     2'b10
`define DTC_MODE_SPLIT      2'b11
`endif

// *** hdl/dtc_edge_detect.v ***
// falling edge detector on synchronous input samples
module dtc_edge_detect
(
    input  wire clk_sys,
    input  wire rst_b,
    input  wire sample_in,
    output wire fall_pulse
);
    reg prev_sample;

    // remember last cycle's sample
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            prev_sample <= 1'b0;
        else
            prev_sample <= sample_in;
    end

    // high then low in the next cycle counts as one edge
    assign fall_pulse = prev_sample & ~sample_in;
endmodule

// *** hdl/dtc_timer.v ***
// dual 16-bit timer/counter with byte registers, gating, toggle outputs and interrupt
`include "dtc_defines.vh"
module dtc_timer
(
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       cnt0_count_pin_in,
    input  wire       cnt1_count_pin_in,
    output reg        cnt0_count_pin_out,
    output reg        cnt1_count_pin_out,
    output reg        cnt0_count_pin_oe_b,
    output reg        cnt1_count_pin_oe_b,
    input  wire       ext_irq_pin_0,
    input  wire       ext_irq_pin_1,
    input  wire       low_speed_crystal_tick,
    input  wire       isr_enter_0,
    input  wire       isr_enter_1,
    output reg        irq
);
    reg  [7:0] timer_mode_select;
    reg  [7:0] clock_control_reg;
    reg  [7:0] aux_ctrl;
    reg        cnt0_run;
    reg        cnt1_run;
    reg        cnt0_overflow_flag;
    reg        cnt1_overflow_flag;
    reg  [7:0] cnt0_low_byte;
    reg  [7:0] cnt0_high_byte;
    reg  [7:0] cnt1_low_byte;
    reg  [7:0] cnt1_high_byte;
    reg  [3:0] prescale;
    reg  [2:0] irq_stat;
    reg  [2:0] irq_mask;
    reg  [7:0] next_rdata;
    wire       fall0;
    wire       fall1;
    wire       pre_tick;

    dtc_edge_detect u_edge0
    (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .sample_in  (cnt0_count_pin_in),
        .fall_pulse (fall0)
    );

    dtc_edge_detect u_edge1
    (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .sample_in  (cnt1_count_pin_in),
        .fall_pulse (fall1)
    );

    // shared divide-by-12 prescaler
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            prescale <= 4'd0;
        else if (prescale == `DTC_PRESCALE_LAST)
            prescale <= 4'd0;
        else
            prescale <= prescale + 4'd1;
    end
    assign pre_tick = (prescale == `DTC_PRESCALE_LAST);

    // pick the increment source of one counter
    function src_tick;
        input ct_sel;
        input clk_mode;
        input lxt_mode;
        input pin_fall;
        input pre;
        input low_speed_crystal;
        begin
            if (lxt_mode)
                src_tick = low_speed_crystal;
            else if (ct_sel)
                src_tick = pin_fall;
            else
                src_tick = clk_mode ? 1'b1 : pre;
        end
    endfunction

    // run bit qualified by gate and irq pin
    function run_ok;
        input run;
        input gate;
        input pin;
        begin
            run_ok = run & (~gate | pin);
        end
    endfunction

    wire tick0 = src_tick(timer_mode_select[`DTC_MODE_CT0],
                          clock_control_reg[`DTC_CLK_MODE0],
                          aux_ctrl[`DTC_AUX_LXT0], fall0, pre_tick,
                          low_speed_crystal_tick);
    wire tick1 = src_tick(timer_mode_select[`DTC_MODE_CT1],
                          clock_control_reg[`DTC_CLK_MODE1],
                          aux_ctrl[`DTC_AUX_LXT1], fall1, pre_tick,
                          low_speed_crystal_tick);
    wire en0   = tick0 & run_ok(cnt0_run, timer_mode_select[`DTC_MODE_GATE0],
                                ext_irq_pin_0);
    wire en1   = tick1 & run_ok(cnt1_run, timer_mode_select[`DTC_MODE_GATE1],
                                ext_irq_pin_1);
    wire [1:0] mode0 = timer_mode_select[1:0];
    wire [1:0] mode1 = timer_mode_select[5:4];
    // in split mode the high byte of counter 0 borrows counter 1's run bit
    wire       en0h  = pre_tick | clock_control_reg[`DTC_CLK_MODE0];
    wire       split = (mode0 == `DTC_MODE_SPLIT);

    // next count and overflow of one counter in modes 0..2
    function [16:0] step;
        input [1:0] mode;
        input [7:0] lo;
        input [7:0] hi;
        begin
            case (mode)
                `DTC_MODE_13BIT:
                begin
                    if (lo[4:0] == 5'h1f)
                        step = {(hi == 8'hff), hi + 8'h01, 8'h00};
                    else
                        step = {1'b0, hi, 3'b000, lo[4:0] + 5'h01};
                end
                `DTC_MODE_16BIT:
                    step = {1'b0, hi, lo} + 17'h00001;
                `DTC_MODE_RELOAD:
                begin
                    if (lo == 8'hff)
                        step = {1'b1, hi, hi};
                    else
                        step = {1'b0, hi, lo + 8'h01};
                end
                default:
                    step = {1'b0, hi, lo};
            endcase
        end
    endfunction

    wire [16:0] st0 = step(mode0, cnt0_low_byte, cnt0_high_byte);
    wire [16:0] st1 = step(mode1, cnt1_low_byte, cnt1_high_byte);
    wire ov0  = split ? (en0 && cnt0_low_byte == 8'hff) : (en0 & st0[16]);
    wire ov0h = split & en0h & cnt1_run & (cnt0_high_byte == 8'hff);
    // counter 1 halted in its mode 3 and never flags while counter 0 is split
    wire ov1  = en1 & st1[16] & ~split;
    wire hit0 = ov0;
    wire hit1 = ov1 | ov0h;

    wire wr_run  = reg_wr && reg_addr == `DTC_ADDR_RUN_CTRL;
    wire wr_stat = reg_wr && reg_addr == `DTC_ADDR_IRQ_STAT;

    // configuration registers
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timer_mode_select <= `DTC_RESET_BYTE;
            clock_control_reg <= `DTC_RESET_BYTE;
            aux_ctrl          <= `DTC_RESET_BYTE;
            cnt0_run          <= 1'b0;
            cnt1_run          <= 1'b0;
            irq_mask          <= 3'b000;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `DTC_ADDR_MODE_SEL: timer_mode_select <= reg_wdata;
                `DTC_ADDR_CLK_CTRL: clock_control_reg <= reg_wdata & 8'h18;
                `DTC_ADDR_AUX_CTRL: aux_ctrl <= reg_wdata & 8'h0f;
                `DTC_ADDR_IRQ_MASK: irq_mask <= reg_wdata[2:0];
                `DTC_ADDR_RUN_CTRL:
                begin
                    cnt0_run <= reg_wdata[`DTC_RUN0];
                    cnt1_run <= reg_wdata[`DTC_RUN1];
                end
                default: ;
            endcase
        end
    end

    // counting registers: a byte write wins over counting that cycle
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt0_low_byte  <= `DTC_RESET_BYTE;
            cnt0_high_byte <= `DTC_RESET_BYTE;
            cnt1_low_byte  <= `DTC_RESET_BYTE;
            cnt1_high_byte <= `DTC_RESET_BYTE;
        end
        else
        begin
            if (reg_wr && reg_addr == `DTC_ADDR_CNT0_LOW)
                cnt0_low_byte <= reg_wdata;
            else if (en0 && split)
                cnt0_low_byte <= cnt0_low_byte + 8'h01;
            else if (en0)
                cnt0_low_byte <= st0[7:0];
            if (reg_wr && reg_addr == `DTC_ADDR_CNT0_HIGH)
                cnt0_high_byte <= reg_wdata;
            else if (split && en0h && cnt1_run)
                cnt0_high_byte <= cnt0_high_byte + 8'h01;
            else if (en0 && !split)
                cnt0_high_byte <= st0[15:8];
            if (reg_wr && reg_addr == `DTC_ADDR_CNT1_LOW)
                cnt1_low_byte <= reg_wdata;
            else if (en1)
                cnt1_low_byte <= st1[7:0];
            if (reg_wr && reg_addr == `DTC_ADDR_CNT1_HIGH)
                cnt1_high_byte <= reg_wdata;
            else if (en1)
                cnt1_high_byte <= st1[15:8];
        end
    end

    // overflow flags: hardware set beats isr and software clear
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt0_overflow_flag <= 1'b0;
            cnt1_overflow_flag <= 1'b0;
        end
        else
        begin
            if (hit0)
                cnt0_overflow_flag <= 1'b1;
            else if (wr_run)
                cnt0_overflow_flag <= reg_wdata[`DTC_FLAG0];
            else if (isr_enter_0)
                cnt0_overflow_flag <= 1'b0;
            if (hit1)
                cnt1_overflow_flag <= 1'b1;
            else if (wr_run)
                cnt1_overflow_flag <= reg_wdata[`DTC_FLAG1];
            else if (isr_enter_1)
                cnt1_overflow_flag <= 1'b0;
        end
    end

    // sticky status: bit0/1 overflow, bit2 count-pin edge; write one clears
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            irq_stat <= 3'b000;
        else
            irq_stat <= (irq_stat & ~(wr_stat ? reg_wdata[2:0] : 3'b000))
                        | {fall0 | fall1, hit1, hit0};
    end

    // toggle outputs; the enable ignores the function select, so software
    // must keep timer function selected for a meaningful pattern
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt0_count_pin_out  <= 1'b1;
            cnt1_count_pin_out  <= 1'b1;
            cnt0_count_pin_oe_b <= 1'b1;
            cnt1_count_pin_oe_b <= 1'b1;
        end
        else
        begin
            cnt0_count_pin_oe_b <= ~aux_ctrl[`DTC_AUX_TOG0];
            cnt1_count_pin_oe_b <= ~aux_ctrl[`DTC_AUX_TOG1];
            if (!aux_ctrl[`DTC_AUX_TOG0])
                cnt0_count_pin_out <= 1'b1;
            else if (hit0)
                cnt0_count_pin_out <= ~cnt0_count_pin_out;
            if (!aux_ctrl[`DTC_AUX_TOG1])
                cnt1_count_pin_out <= 1'b1;
            else if (hit1)
                cnt1_count_pin_out <= ~cnt1_count_pin_out;
        end
    end

    // read mux, data stands one cycle after the strobe
    always @*
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            `DTC_ADDR_RUN_CTRL:  next_rdata = {cnt1_overflow_flag, cnt1_run,
                                               cnt0_overflow_flag, cnt0_run, 4'h0};
            `DTC_ADDR_MODE_SEL:  next_rdata = timer_mode_select;
            `DTC_ADDR_CNT0_LOW:  next_rdata = cnt0_low_byte;
            `DTC_ADDR_CNT1_LOW:  next_rdata = cnt1_low_byte;
            `DTC_ADDR_CNT0_HIGH: next_rdata = cnt0_high_byte;
            `DTC_ADDR_CNT1_HIGH: next_rdata = cnt1_high_byte;
            `DTC_ADDR_CLK_CTRL:  next_rdata = clock_control_reg;
            `DTC_ADDR_AUX_CTRL:  next_rdata = aux_ctrl;
            `DTC_ADDR_IRQ_STAT:  next_rdata = {5'h00, irq_stat};
            `DTC_ADDR_IRQ_MASK:  next_rdata = {5'h00, irq_mask};
            default:             next_rdata = 8'h00;
        endcase
    end

    // read data register and interrupt output
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= 8'h00;
            irq       <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
            irq       <= |(irq_stat & irq_mask);
        end
    end
endmodule

// *** verif/dtc_timer_props.sv ***
// port assertions for the dual timer
`include "dtc_defines.vh"
module dtc_timer_props
(
    input logic       clk_sys,
    input logic       rst_b,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [7:0] reg_rdata,
    input logic       cnt0_count_pin_out,
    input logic       cnt0_count_pin_oe_b,
    input logic       cnt1_count_pin_oe_b,
    input logic       irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // read data stands only in the slot after a read
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside slot");
    property p_unmapped;
        reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    // a mode write is read back unchanged at once
    property p_mode_rb;
        reg_wr && reg_addr == `DTC_ADDR_MODE_SEL ##1 reg_rd && reg_addr == `DTC_ADDR_MODE_SEL
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_mode_rb: assert property (p_mode_rb)
        else $error("mode readback wrong");
    property p_oe0;
        reg_wr && reg_addr == `DTC_ADDR_AUX_CTRL && reg_wdata[0] |-> ##[1:2] !cnt0_count_pin_oe_b;
    endproperty
    a_oe0: assert property (p_oe0)
        else $error("toggle 0 not driven");
    property p_oe1;
        reg_wr && reg_addr == `DTC_ADDR_AUX_CTRL && reg_wdata[1] |-> ##[1:2] !cnt1_count_pin_oe_b;
    endproperty
    a_oe1: assert property (p_oe1)
        else $error("toggle 1 not driven");
    // toggle output starts high when first driven
    property p_tog_start;
        $fell(cnt0_count_pin_oe_b) |-> cnt0_count_pin_out;
    endproperty
    a_tog_start: assert property (p_tog_start)
        else $error("toggle output not high at enable");
    property p_mask_off;
        reg_wr && reg_addr == `DTC_ADDR_IRQ_MASK && reg_wdata == 8'h00 |-> ##2 !irq;
    endproperty
    a_mask_off: assert property (p_mask_off)
        else $error("irq high with all masked");
    // stopped counter gives the same low byte on two reads
    property p_halt;
        reg_wr && reg_addr == `DTC_ADDR_RUN_CTRL && !reg_wdata[4]
            ##1 reg_rd && reg_addr == `DTC_ADDR_CNT0_LOW
            ##1 reg_rd && reg_addr == `DTC_ADDR_CNT0_LOW |=> $stable(reg_rdata);
    endproperty
    a_halt: assert property (p_halt)
        else $error("stopped counter moved");
endmodule
bind dtc_timer dtc_timer_props i_dtc_timer_props
(
    .clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cnt0_count_pin_out, .cnt0_count_pin_oe_b, .cnt1_count_pin_oe_b, .irq
);

// *** verif/dtc_pin_agent.sv ***
// pin-side model: count sources, gate levels and crystal ticks
module dtc_pin_agent
(
    input  logic       clk_sys,
    output logic [1:0] cnt_src,
    output logic [1:0] gate_lvl,
    output logic       xtal_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle: sources high, gates shut, crystal quiet
    initial
    begin
        cnt_src = 2'b11;
        gate_lvl = 2'b00;
        xtal_tick = 1'b0;
    end
    // two samples low, three high: every fall is seen high then low
    task automatic falls(input int k, input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            cnt_src[k] <= 1'b0;
            repeat (2) @(posedge clk_sys);
            cnt_src[k] <= 1'b1;
            repeat (2) @(posedge clk_sys);
        end
    endtask
    task automatic set_gate(input int k, input logic v);
        @(posedge clk_sys);
        gate_lvl[k] <= v;
    endtask
    // gap sets the crystal rate, slow or prompt
    task automatic ticks(input int n, input int gap);
        repeat (n)
        begin
            @(posedge clk_sys);
            xtal_tick <= 1'b1;
            @(posedge clk_sys);
            xtal_tick <= 1'b0;
            repeat (gap) @(posedge clk_sys);
        end
    endtask
endmodule

// *** verif/dtc_timer_tb.sv ***
// self-checking bench for the dual timer
`include "dtc_defines.vh"
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("mismatch at %0t got %h exp %h", $time, got, exp); \
        end \
    end
module dtc_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] run_a = `DTC_ADDR_RUN_CTRL, mode_a = `DTC_ADDR_MODE_SEL,
        lo0_a = `DTC_ADDR_CNT0_LOW, hi0_a = `DTC_ADDR_CNT0_HIGH, lo1_a = `DTC_ADDR_CNT1_LOW,
        hi1_a = `DTC_ADDR_CNT1_HIGH, aux_a = `DTC_ADDR_AUX_CTRL, mask_a = `DTC_ADDR_IRQ_MASK;
    logic       clk_sys;
    logic       rst_b;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [1:0] pin_in;
    logic [1:0] pin_out;
    logic [1:0] oe_b;
    logic [1:0] src;
    logic [1:0] gate;
    logic       xtal;
    logic [1:0] isr;
    logic       irq;
    logic [7:0] d;
    int         fails = 0;
    int         checks_done = 0;
    logic [7:0] rst_tab [12] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e,
        8'h90, 8'h91, 8'h92, 8'h00, 8'h8f};
    logic [7:0] ovf_tab [3][5] = '{'{8'h00, 8'hff, 8'h1f, 8'h00, 8'h01},
        '{8'h01, 8'hff, 8'hff, 8'h00, 8'h01}, '{8'h02, 8'ha0, 8'hff, 8'ha0, 8'ha1}};
    // the pin carries the toggle output while driven, else the outside source
    assign pin_in = (oe_b & src) | (~oe_b & pin_out);
    dtc_timer i_dtc_timer
    (
        .clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
        .cnt0_count_pin_in(pin_in[0]), .cnt1_count_pin_in(pin_in[1]),
        .cnt0_count_pin_out(pin_out[0]), .cnt1_count_pin_out(pin_out[1]),
        .cnt0_count_pin_oe_b(oe_b[0]), .cnt1_count_pin_oe_b(oe_b[1]),
        .ext_irq_pin_0(gate[0]), .ext_irq_pin_1(gate[1]), .low_speed_crystal_tick(xtal),
        .isr_enter_0(isr[0]), .isr_enter_1(isr[1])
    );
    dtc_pin_agent i_dtc_pin_agent (.clk_sys, .cnt_src(src), .gate_lvl(gate), .xtal_tick(xtal));
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // one bus strobe, launched just after an edge
    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= ~w;
        reg_addr <= a;
        reg_wdata <= v;
    endtask
    task automatic idle();
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        op(1'b1, a, v);
        idle();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        op(1'b0, a, 8'h00);
        idle();
        #1 v = reg_rdata;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        rd(a, d);
        `CHK(d, e)
    endtask
    // counts m+2 edges whatever the start and stop latency
    task automatic run_for(input logic [7:0] rc, input int m);
        wr(run_a, rc);
        repeat (m) @(posedge clk_sys);
        wr(run_a, 8'h00);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        close_out();
    end
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        isr = 2'b00;
        rst_b = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        foreach (rst_tab[j])
            chk_rd(rst_tab[j], 8'h00);
        `CHK({oe_b, pin_out, irq}, 5'b11110)
        op(1'b1, mode_a, 8'ha5);
        chk_rd(mode_a, 8'ha5);
        for (int j = 0; j < 4; j++)
            wr(lo0_a + 8'(j), 8'h31 + 8'(j));
        for (int j = 0; j < 4; j++)
            chk_rd(lo0_a + 8'(j), 8'h31 + 8'(j));
        // reset again in mid-run
        @(posedge clk_sys) rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        chk_rd(lo0_a, 8'h00);
        $display("test access done");
        // 120 edges at clock/12 hold exactly 10 ticks whatever the phase
        wr(mode_a, 8'h11);
        run_for(8'h10, 118);
        chk_rd(lo0_a, 8'h0a);
        wr(`DTC_ADDR_CLK_CTRL, 8'h18);
        wr(lo0_a, 8'h00);
        run_for(8'h10, 98);
        chk_rd(lo0_a, 8'h64);
        op(1'b1, run_a, 8'h10);
        op(1'b1, run_a, 8'h00);
        op(1'b0, lo0_a, 8'h00);
        op(1'b0, lo0_a, 8'h00);
        idle();
        #1 `CHK(reg_rdata, 8'h65)
        wr(mode_a, 8'h30);
        run_for(8'h40, 10);
        chk_rd(lo1_a, 8'h00);
        wr(mode_a, 8'h10);
        run_for(8'h40, 10);
        chk_rd(lo1_a, 8'h0c);
        $display("test clocking done");
        wr(aux_a, 8'h03);
        repeat (2) @(posedge clk_sys);
        #1 `CHK({oe_b, pin_out}, 4'b0011)
        for (int i = 0; i < 3; i++)
        begin
            wr(mode_a, ovf_tab[i][0]);
            wr(hi0_a, ovf_tab[i][1]);
            wr(lo0_a, ovf_tab[i][2]);
            run_for(8'h10, 0);
            chk_rd(hi0_a, ovf_tab[i][3]);
            chk_rd(lo0_a, ovf_tab[i][4]);
            `CHK(pin_out[0], 1'(i % 2))
        end
        // the toggled pin falls twice, so the pin-edge status is set too
        rd(`DTC_ADDR_IRQ_STAT, d);
        `CHK(d, 8'h05)
        wr(mask_a, 8'h01);
        repeat (2) @(posedge clk_sys);
        #1 `CHK(irq, 1'b1)
        wr(mask_a, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1 `CHK(irq, 1'b0)
        wr(mask_a, 8'h01);
        wr(`DTC_ADDR_IRQ_STAT, 8'h07);
        repeat (2) @(posedge clk_sys);
        #1 `CHK(irq, 1'b0)
        // split: low byte on counter 0's source, high byte on run 1
        wr(mode_a, 8'h03);
        wr(lo0_a, 8'hfe);
        wr(hi0_a, 8'hff);
        run_for(8'h50, 0);
        chk_rd(lo0_a, 8'h00);
        chk_rd(hi0_a, 8'h01);
        rd(`DTC_ADDR_IRQ_STAT, d);
        `CHK(d, 8'h07)
        `CHK(pin_out, 2'b01)
        wr(mask_a, 8'h02);
        repeat (2) @(posedge clk_sys);
        #1 `CHK(irq, 1'b1)
        $display("test overflow done");
        wr(aux_a, 8'h04);
        wr(mode_a, 8'h01);
        wr(lo0_a, 8'h00);
        wr(run_a, 8'h10);
        i_dtc_pin_agent.ticks(5, 7);
        wr(run_a, 8'h00);
        chk_rd(lo0_a, 8'h05);
        wr(aux_a, 8'h00);
        // pin events: ignored while the gate is shut, then wrap to zero
        for (int k = 0; k < 2; k++)
        begin
            wr(mode_a, k ? 8'hd0 : 8'h0d);
            wr(k ? hi1_a : hi0_a, 8'hff);
            wr(k ? lo1_a : lo0_a, 8'hfd);
            wr(run_a, k ? 8'h40 : 8'h10);
            i_dtc_pin_agent.falls(k, 2);
            i_dtc_pin_agent.set_gate(k, 1'b1);
            i_dtc_pin_agent.falls(k, 3);
            chk_rd(run_a, k ? 8'hc0 : 8'h30);
            @(posedge clk_sys) isr[k] <= 1'b1;
            @(posedge clk_sys) isr[k] <= 1'b0;
            chk_rd(run_a, k ? 8'h40 : 8'h10);
            wr(run_a, 8'h00);
            chk_rd(k ? lo1_a : lo0_a, 8'h00);
            i_dtc_pin_agent.set_gate(k, 1'b0);
        end
        $display("test pins done");
        close_out();
    end
endmodule
